// ==== src/led_defs.vh ====
// Constants for the status indicator lamp driver.
`ifndef LED_DEFS_VH
`define LED_DEFS_VH

// =====================================================================
// Register offsets
`define REG_SLAVE_STATE_REPORT 12'h130
`define REG_STATE_LAMP_FORCE   12'h138
`define REG_FAULT_LAMP_FORCE   12'h139

// =====================================================================
// Register fields and reset values
`define STATE_FIELD_LSB   0
`define STATE_FIELD_MSB   3
`define ERR_IND_BIT       4
`define FORCE_CODE_LSB    0
`define FORCE_CODE_MSB    3
`define FORCE_EN_BIT      4
`define FORCE_RESET       8'h00

// =====================================================================
// Slave state codes
`define ST_INIT           4'h1
`define ST_CONFIG         4'h2
`define ST_FW_UPDATE      4'h3
`define ST_INPUTS_ONLY    4'h4
`define ST_FULL_EXCHANGE  4'h8

// =====================================================================
// Lamp pattern codes
`define PAT_OFF           4'h0
`define PAT_SINGLE        4'h1
`define PAT_DOUBLE        4'h2
`define PAT_TRIPLE        4'h3
`define PAT_BLINK         4'hd
`define PAT_FLICKER       4'he
`define PAT_ON            4'hf

// =====================================================================
// Timing
`define CLK_KHZ           100000
`define FLICKER_MS        50
`define BLINK_MS          200
`define FLICKER_CYCLES    (`FLICKER_MS * `CLK_KHZ)
`define BLINK_CYCLES      (`BLINK_MS * `CLK_KHZ)
`define PHASES_PER_CYCLE  4'd10
`define PHASE_LAST        4'd9

`endif

// ==== src/blink_pattern_gen.v ====
// Prescaler that produces the shared flicker, blink and flash waveforms.
`timescale 1ns/1ps
`include "led_defs.vh"
module blink_pattern_gen #(
  parameter integer FLICKER_CYC = `FLICKER_CYCLES,
  parameter integer BLINK_CYC   = `BLINK_CYCLES
) (
  input  wire       ref_clk_i,
  input  wire       nrst_i,
  output reg        flicker_o,
  output reg        blink_o,
  output reg        single_o,
  output reg        double_o,
  output reg        triple_o,
  output wire       phase_tick_o
);

  reg  [31:0] flk_cnt_q;
  reg  [31:0] blk_cnt_q;
  reg  [3:0]  phase_q;
  wire        flk_end;
  wire        blk_end;

  assign flk_end      = (flk_cnt_q == FLICKER_CYC - 1);
  assign blk_end      = (blk_cnt_q == BLINK_CYC - 1);
  assign phase_tick_o = blk_end;

  // =====================================================================
  // Prescalers
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flk_cnt_q <= 32'h0;
      blk_cnt_q <= 32'h0;
      phase_q   <= 4'h0;
      flicker_o <= 1'b0;
    end else begin
      flk_cnt_q <= flk_end ? 32'h0 : flk_cnt_q + 32'h1;
      blk_cnt_q <= blk_end ? 32'h0 : blk_cnt_q + 32'h1;
      if (flk_end) begin
        flicker_o <= ~flicker_o;
      end
      if (blk_end) begin
        phase_q <= (phase_q == `PHASE_LAST) ? 4'h0 : phase_q + 4'h1;
      end
    end
  end

  // =====================================================================
  // Waveforms over a ten-phase cycle; each flash is one phase long.
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      blink_o  <= 1'b0;
      single_o <= 1'b0;
      double_o <= 1'b0;
      triple_o <= 1'b0;
    end else begin
      blink_o  <= ~phase_q[0];
      single_o <= (phase_q == 4'd0);
      double_o <= (phase_q == 4'd0) | (phase_q == 4'd2);
      triple_o <= (phase_q == 4'd0) | (phase_q == 4'd2) | (phase_q == 4'd4);
    end
  end

endmodule

// ==== src/port_lamp.v ====
// One port's link/activity lamp and receive-fault flash lamp.
`timescale 1ns/1ps
`include "led_defs.vh"
module port_lamp (
  input  wire       ref_clk_i,
  input  wire       nrst_i,
  input  wire       link_up_i,
  input  wire       activity_i,
  input  wire       rx_err_i,
  input  wire       flicker_i,
  input  wire       phase_tick_i,
  output reg        link_lamp_o,
  output reg        fault_lamp_o
);

  localparam S_IDLE = 3'b001;
  localparam S_ON   = 3'b010;
  localparam S_GAP  = 3'b100;

  reg  [1:0] act_hold_q;
  reg  [7:0] pend_q;
  reg  [2:0] st_q;
  wire       take;

  // =====================================================================
  // Activity is held for one to two phases so short frames stay visible.
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      act_hold_q  <= 2'd0;
      link_lamp_o <= 1'b0;
    end else begin
      if (activity_i) begin
        act_hold_q <= 2'd2;
      end else if (phase_tick_i && act_hold_q != 2'd0) begin
        act_hold_q <= act_hold_q - 2'd1;
      end
      link_lamp_o <= link_up_i & ((act_hold_q != 2'd0) ? flicker_i : 1'b1);
    end
  end

  // =====================================================================
  // Each receive error queues one flash; the queue saturates at 255.
  assign take = (st_q == S_IDLE) && (pend_q != 8'h0) && phase_tick_i;

  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pend_q       <= 8'h0;
      st_q         <= S_IDLE;
      fault_lamp_o <= 1'b0;
    end else begin
      if (rx_err_i && !take && pend_q != 8'hff) begin
        pend_q <= pend_q + 8'h1;
      end else if (!rx_err_i && take) begin
        pend_q <= pend_q - 8'h1;
      end
      case (st_q)
        S_IDLE: begin
          if (take) begin
            st_q         <= S_ON;
            fault_lamp_o <= 1'b1;
          end
        end
        S_ON: begin
          if (phase_tick_i) begin
            st_q         <= S_GAP;
            fault_lamp_o <= 1'b0;
          end
        end
        S_GAP: begin
          if (phase_tick_i) begin
            st_q <= S_IDLE;
          end
        end
        default: begin
          st_q         <= S_IDLE;
          fault_lamp_o <= 1'b0;
        end
      endcase
    end
  end

endmodule

// ==== src/status_indicator_led_driver.v ====
// Status indicator lamp driver: state, fault, bicolor and per-port lamps.
`timescale 1ns/1ps
`include "led_defs.vh"
module status_indicator_led_driver #(
  parameter integer FLICKER_CYC     = `FLICKER_CYCLES,
  parameter integer BLINK_CYC       = `BLINK_CYCLES,
  parameter         PROM_LOAD_FLICK = 1'b1
) (
  input  wire       ref_clk_i,
  input  wire       nrst_i,
  input  wire [7:0] slave_state_report_i,
  input  wire       emulation_en_i,
  input  wire       prom_loading_i,
  input  wire       prom_load_err_i,
  input  wire       hw_config_err_i,
  input  wire       pd_wd_timeout_i,
  input  wire       host_wd_timeout_i,
  input  wire       self_test_fail_i,
  input  wire       net_wr_i,
  input  wire [11:0] net_addr_i,
  input  wire [7:0] net_wdata_i,
  input  wire       host_wr_i,
  input  wire [11:0] host_addr_i,
  input  wire [7:0] host_wdata_i,
  input  wire [3:0] comm_established_i,
  input  wire [3:0] port_activity_i,
  input  wire [3:0] port_rx_err_i,
  output wire [7:0] state_lamp_force_o,
  output wire [7:0] fault_lamp_force_o,
  output reg        state_lamp_o,
  output reg        fault_lamp_o,
  output reg        bicolor_green_o,
  output wire [3:0] link_activity_lamp_o,
  output wire [3:0] port_rx_fault_lamp_o
);

  wire       flicker_w;
  wire       blink_w;
  wire       single_w;
  wire       double_w;
  wire       triple_w;
  wire       phase_tick_w;

  reg  [7:0] state_force_q;
  reg  [7:0] fault_force_q;
  reg  [3:0] state_prev_q;
  reg        pd_wd_prev_q;
  reg        host_wd_prev_q;
  reg        pd_wd_latch_q;
  reg        host_wd_latch_q;
  reg  [4:0] auto_cond_q;

  wire [3:0] state_now;
  wire       err_ind;
  wire       state_change;
  wire       pd_wd_edge;
  wire       host_wd_edge;
  wire [4:0] auto_cond;
  wire       new_fault;
  reg  [3:0] state_auto_code;
  reg  [3:0] fault_auto_code;
  wire [3:0] state_code;
  wire [3:0] fault_code;
  wire       state_lamp_d;
  wire       fault_lamp_d;

  // =====================================================================
  // Shared waveform generator
  blink_pattern_gen #(
    .FLICKER_CYC (FLICKER_CYC),
    .BLINK_CYC   (BLINK_CYC)
  ) u_pattern (
    .ref_clk_i    (ref_clk_i),
    .nrst_i       (nrst_i),
    .flicker_o    (flicker_w),
    .blink_o      (blink_w),
    .single_o     (single_w),
    .double_o     (double_w),
    .triple_o     (triple_w),
    .phase_tick_o (phase_tick_w)
  );

  // Maps a pattern code onto the lamp level for this cycle.
  function pattern_level;
    input [3:0] code;
    input       flk;
    input       blk;
    input       sgl;
    input       dbl;
    input       tpl;
    begin
      case (code)
        `PAT_SINGLE:  pattern_level = sgl;
        `PAT_DOUBLE:  pattern_level = dbl;
        `PAT_TRIPLE:  pattern_level = tpl;
        `PAT_BLINK:   pattern_level = blk;
        `PAT_FLICKER: pattern_level = flk;
        `PAT_ON:      pattern_level = 1'b1;
        default:      pattern_level = 1'b0;
      endcase
    end
  endfunction

  // =====================================================================
  // Event detection
  assign state_now    = slave_state_report_i[`STATE_FIELD_MSB:`STATE_FIELD_LSB];
  assign err_ind      = slave_state_report_i[`ERR_IND_BIT];
  assign state_change = (state_now != state_prev_q);
  assign pd_wd_edge   = pd_wd_timeout_i & ~pd_wd_prev_q;
  assign host_wd_edge = host_wd_timeout_i & ~host_wd_prev_q;

  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_prev_q   <= `ST_INIT;
      pd_wd_prev_q   <= 1'b0;
      host_wd_prev_q <= 1'b0;
    end else begin
      state_prev_q   <= state_now;
      pd_wd_prev_q   <= pd_wd_timeout_i;
      host_wd_prev_q <= host_wd_timeout_i;
    end
  end

  // =====================================================================
  // Latched watchdog faults
  // The double flash ends with a state change, so a state change with the error bit set
  // falls back to single flash unless the host forces it again.
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pd_wd_latch_q   <= 1'b0;
      host_wd_latch_q <= 1'b0;
    end else begin
      if (pd_wd_edge && state_now == `ST_FULL_EXCHANGE) begin
        pd_wd_latch_q <= 1'b1;
      end else if (state_change || !pd_wd_timeout_i) begin
        pd_wd_latch_q <= 1'b0;
      end
      if (host_wd_edge) begin
        host_wd_latch_q <= 1'b1;
      end else if (!host_wd_timeout_i) begin
        host_wd_latch_q <= 1'b0;
      end
    end
  end

  // Fault conditions in order of severity, most severe in bit 4.
  assign auto_cond = {host_wd_latch_q | self_test_fail_i,
                      pd_wd_latch_q,
                      prom_load_err_i,
                      hw_config_err_i,
                      err_ind & ~emulation_en_i};
  assign new_fault = |(auto_cond & ~auto_cond_q);

  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      auto_cond_q <= 5'h0;
    end else begin
      auto_cond_q <= auto_cond;
    end
  end

  // =====================================================================
  // Force registers, written by either side; the local host port wins a tie.
  // A write in the same cycle as an automatic cancel is kept.
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_force_q <= `FORCE_RESET;
      fault_force_q <= `FORCE_RESET;
    end else begin
      if (host_wr_i && host_addr_i == `REG_STATE_LAMP_FORCE) begin
        state_force_q <= host_wdata_i;
      end else if (net_wr_i && net_addr_i == `REG_STATE_LAMP_FORCE) begin
        state_force_q <= net_wdata_i;
      end else if (state_change) begin
        state_force_q <= `FORCE_RESET;
      end
      if (host_wr_i && host_addr_i == `REG_FAULT_LAMP_FORCE) begin
        fault_force_q <= host_wdata_i;
      end else if (net_wr_i && net_addr_i == `REG_FAULT_LAMP_FORCE) begin
        fault_force_q <= net_wdata_i;
      end else if (new_fault) begin
        fault_force_q <= `FORCE_RESET;
      end
    end
  end

  assign state_lamp_force_o = state_force_q;
  assign fault_lamp_force_o = fault_force_q;

  // =====================================================================
  // Automatic pattern selection
  always @* begin
    case (state_now)
      `ST_INIT:          state_auto_code = `PAT_OFF;
      `ST_CONFIG:        state_auto_code = `PAT_BLINK;
      `ST_INPUTS_ONLY:   state_auto_code = `PAT_SINGLE;
      `ST_FULL_EXCHANGE: state_auto_code = `PAT_ON;
      `ST_FW_UPDATE:     state_auto_code = `PAT_FLICKER;
      default:           state_auto_code = `PAT_OFF;
    endcase
    if (PROM_LOAD_FLICK && prom_loading_i) begin
      state_auto_code = `PAT_FLICKER;
    end
  end

  always @* begin
    if (auto_cond[4]) begin
      fault_auto_code = `PAT_ON;
    end else if (auto_cond[3]) begin
      fault_auto_code = `PAT_DOUBLE;
    end else if (auto_cond[2]) begin
      fault_auto_code = `PAT_FLICKER;
    end else if (auto_cond[1]) begin
      fault_auto_code = `PAT_BLINK;
    end else if (auto_cond[0]) begin
      fault_auto_code = `PAT_SINGLE;
    end else begin
      fault_auto_code = `PAT_OFF;
    end
  end

  assign state_code = state_force_q[`FORCE_EN_BIT]
                    ? state_force_q[`FORCE_CODE_MSB:`FORCE_CODE_LSB] : state_auto_code;
  assign fault_code = fault_force_q[`FORCE_EN_BIT]
                    ? fault_force_q[`FORCE_CODE_MSB:`FORCE_CODE_LSB] : fault_auto_code;

  assign state_lamp_d = pattern_level(state_code, flicker_w, blink_w,
                                      single_w, double_w, triple_w);
  assign fault_lamp_d = pattern_level(fault_code, flicker_w, blink_w,
                                      single_w, double_w, triple_w);

  // =====================================================================
  // Lamp outputs
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_lamp_o    <= 1'b0;
      fault_lamp_o    <= 1'b0;
      bicolor_green_o <= 1'b0;
    end else begin
      state_lamp_o    <= state_lamp_d;
      fault_lamp_o    <= fault_lamp_d;
      bicolor_green_o <= state_lamp_d & ~fault_lamp_d;
    end
  end

  // =====================================================================
  // Per-port lamps
  genvar p;
  generate
    for (p = 0; p < 4; p = p + 1) begin : g_port
      port_lamp u_port (
        .ref_clk_i    (ref_clk_i),
        .nrst_i       (nrst_i),
        .link_up_i    (comm_established_i[p]),
        .activity_i   (port_activity_i[p]),
        .rx_err_i     (port_rx_err_i[p]),
        .flicker_i    (flicker_w),
        .phase_tick_i (phase_tick_w),
        .link_lamp_o  (link_activity_lamp_o[p]),
        .fault_lamp_o (port_rx_fault_lamp_o[p])
      );
    end
  endgenerate

endmodule

// ==== tb/status_indicator_led_driver_checker.sv ====
// Port-level checks for the status indicator lamp driver.
`timescale 1ns/1ps
module led_driver_checker #(
  parameter integer BLINK_CYC = 16
) (
  input wire        ref_clk_i,
  input wire        nrst_i,
  input wire [7:0]  slave_state_report_i,
  input wire        prom_loading_i,
  input wire        hw_config_err_i,
  input wire        self_test_fail_i,
  input wire        net_wr_i,
  input wire [11:0] net_addr_i,
  input wire [7:0]  net_wdata_i,
  input wire        host_wr_i,
  input wire [11:0] host_addr_i,
  input wire [7:0]  host_wdata_i,
  input wire [3:0]  comm_established_i,
  input wire [3:0]  port_activity_i,
  input wire [7:0]  state_lamp_force_o,
  input wire [7:0]  fault_lamp_force_o,
  input wire        state_lamp_o,
  input wire        fault_lamp_o,
  input wire        bicolor_green_o,
  input wire [3:0]  link_activity_lamp_o
);
  // ==========================================================
  // Helper logic
  wire       st_wr = (host_wr_i && host_addr_i == 12'h138) || (net_wr_i && net_addr_i == 12'h138);
  wire       h_fl  = host_wr_i && host_addr_i == 12'h139;
  wire       fl_wr = h_fl || (net_wr_i && net_addr_i == 12'h139);
  reg [15:0] idle_q;
  // Counts how long port 0 has held its link without traffic.
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      idle_q <= 16'h0000;
    end else if (!comm_established_i[0] || port_activity_i[0]) begin
      idle_q <= 16'h0000;
    end else if (idle_q != 16'hffff) begin
      idle_q <= idle_q + 16'h0001;
    end
  end
  // ==========================================================
  // Assertions
  default clocking dc @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  a_green_excludes_fault: assert property (
    bicolor_green_o == (state_lamp_o && !fault_lamp_o)) else $error("green lit with fault");
  a_host_state_write: assert property (
    host_wr_i && host_addr_i == 12'h138 |=> state_lamp_force_o == $past(host_wdata_i))
    else $error("state force write lost");
  a_net_fault_write: assert property (
    net_wr_i && net_addr_i == 12'h139 && !h_fl |=> fault_lamp_force_o == $past(net_wdata_i))
    else $error("fault force write lost");
  a_state_force_cancel: assert property (
    slave_state_report_i[3:0] != $past(slave_state_report_i[3:0]) && !st_wr
    |=> state_lamp_force_o == 8'h00) else $error("state force kept");
  a_fault_force_cancel: assert property (
    ($rose(hw_config_err_i) || $rose(self_test_fail_i)) && !fl_wr
    |=> fault_lamp_force_o == 8'h00) else $error("fault force kept");
  a_link_lamp_off: assert property (
    (link_activity_lamp_o & ~$past(comm_established_i)) == 4'h0) else $error("lamp without link");
  a_link_idle_on: assert property (
    idle_q > 3 * BLINK_CYC |-> link_activity_lamp_o[0]) else $error("idle link lamp dark");
  a_init_lamp_off: assert property (
    (slave_state_report_i[3:0] == 4'h1 && !prom_loading_i && !state_lamp_force_o[4])[*2]
    |=> !state_lamp_o) else $error("init lamp lit");
  a_full_lamp_on: assert property (
    (slave_state_report_i[3:0] == 4'h8 && !prom_loading_i && !state_lamp_force_o[4])[*2]
    |=> state_lamp_o) else $error("full exchange lamp dark");
  a_self_test_on: assert property (
    (self_test_fail_i && !fault_lamp_force_o[4])[*3] |=> fault_lamp_o)
    else $error("self-test fault lamp dark");
endmodule

bind status_indicator_led_driver led_driver_checker #(.BLINK_CYC(BLINK_CYC)) u_chk (
  .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .slave_state_report_i(slave_state_report_i),
  .prom_loading_i(prom_loading_i), .hw_config_err_i(hw_config_err_i),
  .self_test_fail_i(self_test_fail_i), .net_wr_i(net_wr_i), .net_addr_i(net_addr_i),
  .net_wdata_i(net_wdata_i), .host_wr_i(host_wr_i), .host_addr_i(host_addr_i),
  .host_wdata_i(host_wdata_i), .comm_established_i(comm_established_i),
  .port_activity_i(port_activity_i), .state_lamp_force_o(state_lamp_force_o),
  .fault_lamp_force_o(fault_lamp_force_o), .state_lamp_o(state_lamp_o),
  .fault_lamp_o(fault_lamp_o), .bicolor_green_o(bicolor_green_o),
  .link_activity_lamp_o(link_activity_lamp_o));

// ==== tb/led_observer.sv ====
// Board lamp model that counts lit cycles and switch-on events.
`timescale 1ns/1ps
module led_observer (
  input  wire        ref_clk_i,
  input  wire        clear_i,
  input  wire        lamp_i,
  output reg  [15:0] lit_cnt_o,
  output reg  [15:0] rise_cnt_o
);
  reg last_q;
  always @(posedge ref_clk_i) begin
    last_q <= lamp_i;
    if (clear_i) begin
      lit_cnt_o  <= 16'h0000;
      rise_cnt_o <= 16'h0000;
    end else begin
      lit_cnt_o  <= lit_cnt_o + {15'h0000, lamp_i};
      rise_cnt_o <= rise_cnt_o + {15'h0000, lamp_i & ~last_q};
    end
  end
endmodule

// ==== tb/status_indicator_led_driver_tb_top.sv ====
// Self-checking bench for the status indicator lamp driver.
`timescale 1ns/1ps
`include "led_defs.vh"
module status_indicator_led_driver_tb_top;
  reg         ref_clk_i, nrst_i, emulation_en_i, prom_loading_i, prom_load_err_i;
  reg         hw_config_err_i, pd_wd_timeout_i, host_wd_timeout_i, self_test_fail_i;
  reg         net_wr_i, host_wr_i, clr;
  reg  [7:0]  slave_state_report_i, net_wdata_i, host_wdata_i;
  reg  [11:0] net_addr_i, host_addr_i;
  reg  [3:0]  comm_established_i, port_activity_i, port_rx_err_i, act_mask, sel;
  wire [7:0]  state_lamp_force_o, fault_lamp_force_o;
  wire        state_lamp_o, fault_lamp_o, bicolor_green_o;
  wire [3:0]  link_activity_lamp_o, port_rx_fault_lamp_o;
  wire [15:0] lit_cnt, rise_cnt;
  reg  [15:0] lit_n, rise_n, cyc;
  integer     err_total, num_checks, i;
  reg  [3:0]  st_t [0:5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h1};
  reg  [15:0] lit_t [0:5] = '{16'h0, 16'h50, 16'h10, 16'ha0, 16'h50, 16'h50};
  reg  [15:0] rs_t [0:5] = '{16'h0, 16'h5, 16'h1, 16'h0, 16'h14, 16'h14};
  reg  [3:0]  fc_t [0:6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hd, 4'he, 4'hf};
  reg  [15:0] fl_t [0:6] = '{16'h0, 16'h10, 16'h20, 16'h30, 16'h50, 16'h50, 16'ha0};
  wire [9:0]  lamps = {port_rx_fault_lamp_o, link_activity_lamp_o, fault_lamp_o, state_lamp_o};
  status_indicator_led_driver #(.FLICKER_CYC(4), .BLINK_CYC(16), .PROM_LOAD_FLICK(1'b1)) dut (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .slave_state_report_i(slave_state_report_i),
    .emulation_en_i(emulation_en_i), .prom_loading_i(prom_loading_i),
    .prom_load_err_i(prom_load_err_i), .hw_config_err_i(hw_config_err_i),
    .pd_wd_timeout_i(pd_wd_timeout_i), .host_wd_timeout_i(host_wd_timeout_i),
    .self_test_fail_i(self_test_fail_i), .net_wr_i(net_wr_i), .net_addr_i(net_addr_i),
    .net_wdata_i(net_wdata_i), .host_wr_i(host_wr_i), .host_addr_i(host_addr_i),
    .host_wdata_i(host_wdata_i), .comm_established_i(comm_established_i),
    .port_activity_i(port_activity_i), .port_rx_err_i(port_rx_err_i),
    .state_lamp_force_o(state_lamp_force_o), .fault_lamp_force_o(fault_lamp_force_o),
    .state_lamp_o(state_lamp_o), .fault_lamp_o(fault_lamp_o),
    .bicolor_green_o(bicolor_green_o), .link_activity_lamp_o(link_activity_lamp_o),
    .port_rx_fault_lamp_o(port_rx_fault_lamp_o));
  led_observer u_led (.ref_clk_i(ref_clk_i), .clear_i(clr), .lamp_i(lamps[sel]),
    .lit_cnt_o(lit_cnt), .rise_cnt_o(rise_cnt));
  // ==========================================================
  // Clock, traffic and timeout
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 16'h0001;
    port_activity_i <= (cyc[3:0] == 4'h0) ? act_mask : 4'h0;
    if (cyc == 16'd30000) begin
      err_total = err_total + 1;
      report_and_stop;
    end
  end
  // ==========================================================
  // Shared tasks
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task wr(input hw, input [11:0] ha, input [7:0] hd, input nw, input [11:0] na, input [7:0] nd);
    begin
      host_wr_i <= hw;
      host_addr_i <= ha;
      host_wdata_i <= hd;
      net_wr_i <= nw;
      net_addr_i <= na;
      net_wdata_i <= nd;
      @(posedge ref_clk_i);
      host_wr_i <= 1'b0;
      net_wr_i <= 1'b0;
      @(posedge ref_clk_i);
    end
  endtask
  // Settles for w cycles, then watches lamp s for one 160-cycle pattern period.
  task meas(input [3:0] s, input [7:0] w);
    begin
      sel <= s;
      repeat (w) @(posedge ref_clk_i);
      clr <= 1'b1;
      @(posedge ref_clk_i);
      clr <= 1'b0;
      repeat (160) @(posedge ref_clk_i);
      #1;
      lit_n = lit_cnt;
      rise_n = rise_cnt;
      @(posedge ref_clk_i);
    end
  endtask
  task fm(input [15:0] l, input [15:0] r);
    begin
      meas(4'd1, 8'd40);
      chk(lit_n, l);
      chk(rise_n, r);
    end
  endtask
  task report_and_stop;
    begin
      $display("checks=%0d mismatches=%0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
        $display("Result: passed");
      end else begin
        $display("Result: failed");
      end
      $finish;
    end
  endtask
  // ==========================================================
  // Scenarios
  task t_state;
    begin
      chk({8'h00, state_lamp_force_o}, {8'h00, `FORCE_RESET});
      chk({8'h00, fault_lamp_force_o}, {8'h00, `FORCE_RESET});
      for (i = 0; i < 6; i = i + 1) begin
        slave_state_report_i <= {4'h0, st_t[i]};
        prom_loading_i <= (i == 5);
        meas(4'd0, 8'd40);
        chk(lit_n, lit_t[i]);
        chk(rise_n, rs_t[i]);
      end
      prom_loading_i <= 1'b0;
      $display("t_state done");
    end
  endtask
  task t_force;
    begin
      for (i = 0; i < 7; i = i + 1) begin
        wr(1'b1, `REG_STATE_LAMP_FORCE, {4'h1, fc_t[i]},
           1'b1, `REG_FAULT_LAMP_FORCE, {4'h1, fc_t[i]});
        meas(4'd0, 8'd40);
        chk(lit_n, fl_t[i]);
        meas(4'd1, 8'd0);
        chk(lit_n, fl_t[i]);
      end
      wr(1'b1, 12'h138, 8'h13, 1'b1, 12'h138, 8'h1f);
      chk({8'h00, state_lamp_force_o}, 16'h0013);
      wr(1'b1, 12'h137, 8'hff, 1'b1, 12'h13a, 8'hff);
      chk({state_lamp_force_o, fault_lamp_force_o}, 16'h131f);
      meas(4'd0, 8'd40);
      chk(rise_n, 16'h0003);
      slave_state_report_i <= {4'h0, `ST_CONFIG};
      repeat (3) @(posedge ref_clk_i);
      chk({state_lamp_force_o, fault_lamp_force_o}, 16'h001f);
      wr(1'b0, 12'h000, 8'h00, 1'b1, 12'h139, 8'h00);
      meas(4'd0, 8'd40);
      chk(lit_n, 16'h0050);
      $display("t_force done");
    end
  endtask
  task t_fault;
    begin
      slave_state_report_i <= 8'h18;
      fm(16'h0010, 16'h0001);
      emulation_en_i <= 1'b1;
      fm(16'h0000, 16'h0000);
      emulation_en_i <= 1'b0;
      pd_wd_timeout_i <= 1'b1;
      fm(16'h0020, 16'h0002);
      slave_state_report_i <= 8'h14;
      fm(16'h0010, 16'h0001);
      wr(1'b0, 12'h000, 8'h00, 1'b1, 12'h139, 8'h1f);
      hw_config_err_i <= 1'b1;
      fm(16'h0050, 16'h0005);
      prom_load_err_i <= 1'b1;
      fm(16'h0050, 16'h0014);
      pd_wd_timeout_i <= 1'b0;
      slave_state_report_i <= 8'h18;
      @(posedge ref_clk_i);
      pd_wd_timeout_i <= 1'b1;
      fm(16'h0020, 16'h0002);
      wr(1'b0, 12'h000, 8'h00, 1'b1, 12'h139, 8'h10);
      host_wd_timeout_i <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
      chk({8'h00, fault_lamp_force_o}, 16'h0000);
      fm(16'h00a0, 16'h0000);
      {host_wd_timeout_i, pd_wd_timeout_i, hw_config_err_i, prom_load_err_i} <= 4'h0;
      slave_state_report_i <= 8'h08;
      self_test_fail_i <= 1'b1;
      fm(16'h00a0, 16'h0000);
      chk({15'h0000, bicolor_green_o}, 16'h0000);
      self_test_fail_i <= 1'b0;
      fm(16'h0000, 16'h0000);
      chk({15'h0000, bicolor_green_o}, 16'h0001);
      $display("t_fault done");
    end
  endtask
  task t_ports;
    begin
      meas(4'd2, 8'd40);
      chk(lit_n, 16'h0000);
      comm_established_i <= 4'h3;
      act_mask <= 4'h2;
      meas(4'd2, 8'd80);
      chk(lit_n, 16'h00a0);
      meas(4'd3, 8'd0);
      chk(lit_n, 16'h0050);
      comm_established_i <= 4'h1;
      meas(4'd3, 8'd8);
      chk(lit_n, 16'h0000);
      act_mask <= 4'h0;
      // Starts the errors just after a phase tick so all three flashes fall in the window.
      while (cyc[3:0] != 4'h3) begin
        @(posedge ref_clk_i);
      end
      port_rx_err_i <= 4'h4;
      repeat (3) @(posedge ref_clk_i);
      port_rx_err_i <= 4'h0;
      meas(4'd8, 8'd0);
      chk(rise_n, 16'h0003);
      chk(lit_n, 16'h0030);
      $display("t_ports done");
    end
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    {nrst_i, emulation_en_i, prom_loading_i, prom_load_err_i, hw_config_err_i} = 5'h00;
    {pd_wd_timeout_i, host_wd_timeout_i, self_test_fail_i, net_wr_i, host_wr_i} = 5'h00;
    {net_addr_i, host_addr_i, net_wdata_i, host_wdata_i} = 40'h0;
    {comm_established_i, port_rx_err_i, act_mask, sel} = 16'h0;
    slave_state_report_i = {4'h0, `ST_INIT};
    clr = 1'b0;
    cyc = 16'h0000;
    err_total = 0;
    num_checks = 0;
    repeat (20) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    @(posedge ref_clk_i);
    t_state;
    t_force;
    t_fault;
    t_ports;
    report_and_stop;
  end
endmodule
